// ===== common/io_ts_map.vh
// Constants for the timestamp and output schedule unit
`ifndef IO_TS_MAP_VH
`define IO_TS_MAP_VH
`define CLK_PERIOD_NS 4
`define COALESCE_WINDOW_US 500
`define COALESCE_CYCLES ((`COALESCE_WINDOW_US * 1000) / `CLK_PERIOD_NS)
`define TIME_RESET_VALUE 64'h0000000000000000
`define NS_PER_TICK 64'h0000000000000004
`endif

// ===== logic/io_timestamp_schedule_unit.v
// Timestamp capture and output schedule unit
`timescale 1ns/1ns
`include "io_ts_map.vh"
module io_timestamp_schedule_unit #(
	parameter POINTS = 16,
	parameter COALESCE_CYCLES = `COALESCE_CYCLES,
	parameter INTERVAL_W = 32
) (
	// Clock and reset
	input wire clock,
	input wire rst_n,
	// Time follower inputs from the sync engine
	input wire time_load,
	input wire [63:0] time_load_value,
	input wire [63:0] local_to_system_offset,
	input wire sync_enable,
	// Mode and configuration
	input wire chassis_time_mode,
	input wire [POINTS-1:0] change_notify,
	input wire [INTERVAL_W-1:0] update_interval,
	// Field inputs
	input wire [POINTS-1:0] field_in,
	// Output schedule request
	input wire sched_valid,
	input wire [63:0] sched_time,
	input wire [$clog2(POINTS)-1:0] sched_point,
	input wire sched_value,
	output wire sched_ready,
	// Field outputs
	output reg [POINTS-1:0] field_out_ff,
	output reg [63:0] out_applied_time_ff,
	// Input transfer to controller
	output reg xfer_valid_ff,
	output reg [POINTS-1:0] xfer_data_ff,
	output reg [63:0] xfer_stamp_ff,
	output reg [63:0] xfer_offset_ff,
	output reg [64*POINTS-1:0] point_stamp_ff,
	output reg [63:0] chassis_time_ff,
	output wire [63:0] system_time
);
	localparam PTR_W = $clog2(POINTS);
	localparam [31:0] COAL_LOAD = COALESCE_CYCLES - 1;

	// Time base
	reg [63:0] sys_time_ff;
	reg [63:0] nxt_sys_time;
	reg [63:0] nxt_chassis_time;
	// Field pin synchroniser and edge history
	reg [POINTS-1:0] in_meta_ff;
	reg [POINTS-1:0] in_sync_ff;
	reg [POINTS-1:0] in_prev_ff;
	// Update interval and coalescing counters
	reg [INTERVAL_W-1:0] ivl_cnt_ff;
	reg [INTERVAL_W-1:0] nxt_ivl_cnt;
	reg [31:0] coal_cnt_ff;
	reg [31:0] nxt_coal_cnt;
	reg [63:0] coal_stamp_ff;
	reg [63:0] nxt_coal_stamp;
	// Input transfer next values
	reg nxt_xfer_valid;
	reg [POINTS-1:0] nxt_xfer_data;
	reg [63:0] nxt_xfer_stamp;
	reg [63:0] nxt_xfer_offset;
	wire [64*POINTS-1:0] nxt_point_stamp;
	// Pending schedule entry
	reg pend_valid_ff;
	reg [63:0] pend_time_ff;
	reg [PTR_W-1:0] pend_point_ff;
	reg pend_value_ff;
	reg nxt_pend_valid;
	reg [63:0] nxt_pend_time;
	reg [PTR_W-1:0] nxt_pend_point;
	reg nxt_pend_value;
	reg [POINTS-1:0] nxt_field_out;
	reg [63:0] nxt_out_applied_time;
	// Decoded conditions
	wire [POINTS-1:0] changed;
	wire [POINTS-1:0] notify_hit;
	wire any_hit;
	wire interval_tick;
	wire coal_open;
	wire fire;
	wire accept;
	wire [63:0] chassis_now;

	assign changed = in_sync_ff ^ in_prev_ff;
	assign notify_hit = changed & change_notify;
	assign any_hit = |notify_hit;
	assign interval_tick = (ivl_cnt_ff == {INTERVAL_W{1'b0}});
	assign coal_open = (coal_cnt_ff != 32'h00000000);
	// Full-width compare, so no wrap limits how far ahead a schedule sits
	assign fire = pend_valid_ff && (sys_time_ff >= pend_time_ff);
	assign accept = sched_valid && sched_ready;
	// Chassis time of this cycle, from system time and offset
	assign chassis_now = sys_time_ff - local_to_system_offset;
	// Follower: time is loaded from outside, and also published on system_time
	assign system_time = sys_time_ff;
	assign sched_ready = !pend_valid_ff || fire;

	// Free-running time, corrected by the sync engine
	always @* begin
		if (time_load && sync_enable) begin
			nxt_sys_time = time_load_value;
		end else begin
			nxt_sys_time = sys_time_ff + `NS_PER_TICK;
		end
		// Chassis time kept live every cycle, synchronized or not
		nxt_chassis_time = chassis_now;
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			sys_time_ff <= `TIME_RESET_VALUE;
			chassis_time_ff <= `TIME_RESET_VALUE;
		end else begin
			sys_time_ff <= nxt_sys_time;
			chassis_time_ff <= nxt_chassis_time;
		end
	end

	// Two-flop synchroniser on the field pins
	always @(posedge clock) begin
		if (!rst_n) begin
			in_meta_ff <= {POINTS{1'b0}};
			in_sync_ff <= {POINTS{1'b0}};
			in_prev_ff <= {POINTS{1'b0}};
		end else begin
			in_meta_ff <= field_in;
			in_sync_ff <= in_meta_ff;
			in_prev_ff <= in_sync_ff;
		end
	end

	// Per-point stamps latched in the detect cycle
	genvar g;
	generate
		for (g = 0; g < POINTS; g = g + 1) begin : g_pt
			assign nxt_point_stamp[64*g +: 64] = changed[g] ? sys_time_ff :
				point_stamp_ff[64*g +: 64];
		end
	endgenerate

	// One process owns the whole stamp vector, so each bit has one driver
	always @(posedge clock) begin
		if (!rst_n)
			point_stamp_ff <= {POINTS{`TIME_RESET_VALUE}};
		else
			point_stamp_ff <= nxt_point_stamp;
	end

	// Interval counter; a shared interval gives a shared sample grid
	always @* begin
		if (interval_tick)
			nxt_ivl_cnt = update_interval;
		else
			nxt_ivl_cnt = ivl_cnt_ff - {{(INTERVAL_W-1){1'b0}}, 1'b1};
	end

	// Coalescing window for chassis-time mode
	always @* begin
		nxt_coal_cnt = coal_cnt_ff;
		nxt_coal_stamp = coal_stamp_ff;
		if (any_hit && !coal_open) begin
			// First notified change opens the window and fixes its stamp
			nxt_coal_cnt = COAL_LOAD;
			nxt_coal_stamp = chassis_now;
		end else if (coal_open) begin
			nxt_coal_cnt = coal_cnt_ff - 32'h00000001;
		end
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			ivl_cnt_ff <= {INTERVAL_W{1'b0}};
			coal_cnt_ff <= 32'h00000000;
			coal_stamp_ff <= `TIME_RESET_VALUE;
		end else begin
			ivl_cnt_ff <= nxt_ivl_cnt;
			coal_cnt_ff <= nxt_coal_cnt;
			coal_stamp_ff <= nxt_coal_stamp;
		end
	end

	// Input transfer: every interval, and on notified change
	always @* begin
		nxt_xfer_valid = interval_tick || any_hit;
		nxt_xfer_data = xfer_data_ff;
		nxt_xfer_stamp = xfer_stamp_ff;
		nxt_xfer_offset = xfer_offset_ff;
		if (interval_tick || any_hit) begin
			nxt_xfer_data = in_sync_ff;
			nxt_xfer_offset = local_to_system_offset;
			if (chassis_time_mode) begin
				// Changes inside the window reuse the first stamp
				if (any_hit && !coal_open)
					nxt_xfer_stamp = chassis_now;
				else
					nxt_xfer_stamp = coal_stamp_ff;
			end else begin
				nxt_xfer_stamp = sys_time_ff;
			end
		end
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			xfer_valid_ff <= 1'b0;
			xfer_data_ff <= {POINTS{1'b0}};
			xfer_stamp_ff <= `TIME_RESET_VALUE;
			xfer_offset_ff <= `TIME_RESET_VALUE;
		end else begin
			xfer_valid_ff <= nxt_xfer_valid;
			xfer_data_ff <= nxt_xfer_data;
			xfer_stamp_ff <= nxt_xfer_stamp;
			xfer_offset_ff <= nxt_xfer_offset;
		end
	end

	// One pending schedule entry; a single slot keeps ordering trivial
	always @* begin
		nxt_pend_valid = pend_valid_ff;
		nxt_pend_time = pend_time_ff;
		nxt_pend_point = pend_point_ff;
		nxt_pend_value = pend_value_ff;
		nxt_field_out = field_out_ff;
		nxt_out_applied_time = out_applied_time_ff;
		if (fire) begin
			nxt_field_out[pend_point_ff] = pend_value_ff;
			nxt_out_applied_time = sys_time_ff;
			nxt_pend_valid = 1'b0;
		end
		// A new request may load in the cycle the old one fires
		if (accept) begin
			nxt_pend_valid = 1'b1;
			nxt_pend_time = sched_time;
			nxt_pend_point = sched_point;
			nxt_pend_value = sched_value;
		end
	end

	always @(posedge clock) begin
		if (!rst_n) begin
			pend_valid_ff <= 1'b0;
			pend_time_ff <= `TIME_RESET_VALUE;
			pend_point_ff <= {PTR_W{1'b0}};
			pend_value_ff <= 1'b0;
			field_out_ff <= {POINTS{1'b0}};
			out_applied_time_ff <= `TIME_RESET_VALUE;
		end else begin
			pend_valid_ff <= nxt_pend_valid;
			pend_time_ff <= nxt_pend_time;
			pend_point_ff <= nxt_pend_point;
			pend_value_ff <= nxt_pend_value;
			field_out_ff <= nxt_field_out;
			out_applied_time_ff <= nxt_out_applied_time;
		end
	end
endmodule

// ===== verif/io_ts_asserts.sv
// Checks on time, stamps and schedules
`timescale 1ns/1ns
module io_ts_asserts #(parameter POINTS = 16) (
	// Strobes
	input wire clock, rst_n, time_load, chassis_time_mode, sched_valid, sched_ready, xfer_valid_ff,
	// Words
	input wire [63:0] sched_time, local_to_system_offset, system_time, chassis_time_ff,
	input wire [63:0] out_applied_time_ff, xfer_stamp_ff, xfer_offset_ff,
	input wire [POINTS-1:0] field_out_ff,
	input wire [64*POINTS-1:0] point_stamp_ff
);
	reg [63:0] t_ff, due_ff;
	always @(posedge clock) t_ff <= system_time;
	always @(posedge clock) if (sched_valid && sched_ready) due_ff <= sched_time;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_far; sched_valid && sched_ready && sched_time > system_time + 64'h40; endsequence
	a_time_tick: assert property ($past(rst_n, 3) && !$past(time_load)
		|-> system_time == t_ff + 64'h4) else $error("time step");
	a_chassis_rel: assert property ($past(rst_n, 3)
		|-> chassis_time_ff == t_ff - local_to_system_offset) else $error("chassis");
	a_offset_rpt: assert property (xfer_valid_ff
		|-> xfer_offset_ff == local_to_system_offset) else $error("offset");
	a_xfer_stamp: assert property (xfer_valid_ff && !chassis_time_mode
		|-> xfer_stamp_ff == t_ff) else $error("stamp");
	a_point_own: assert property (!chassis_time_mode && $changed(point_stamp_ff[63:0])
		|-> point_stamp_ff[63:0] == t_ff) else $error("point");
	a_no_early: assert property ($changed(field_out_ff) |-> t_ff >= $past(due_ff))
		else $error("early");
	a_applied_t: assert property ($changed(field_out_ff)
		|-> out_applied_time_ff == t_ff) else $error("applied");
	a_ready_drop: assert property (s_far |=> !sched_ready) else $error("ready");
endmodule
bind io_timestamp_schedule_unit io_ts_asserts #(.POINTS(POINTS)) chk (.*);

// ===== verif/owner_ctrl.sv
// Owner controller: time source and schedule sender
`timescale 1ns/1ns
module owner_ctrl (
	input wire clock, sched_ready,
	output reg sched_valid = 0, sched_value = 0, time_load = 0, sync_enable = 1,
	output reg [63:0] sched_time = 0, time_load_value = 0,
	output reg [1:0] sched_point = 0
);
	// Released time words show the inverse, so a stale value cannot pass; point and value hold
	task send(input [63:0] t, input [1:0] p, input v);
		@(negedge clock);
		{sched_valid, sched_time, sched_point, sched_value} = {1'b1, t, p, v};
		do @(posedge clock); while (sched_ready !== 1'b1);
		@(negedge clock);
		{sched_valid, sched_time} = {1'b0, ~t};
	endtask
	task load(input [63:0] v);
		@(negedge clock);
		{time_load, time_load_value} = {1'b1, v};
		@(negedge clock);
		{time_load, time_load_value} = {1'b0, ~v};
	endtask
endmodule

// ===== verif/tb_top.sv
// Bench for the timestamp and schedule unit
`timescale 1ns/1ns
module tb_top;
	reg clock = 0, rst_n = 0, chassis_time_mode = 0;
	reg [3:0] field_in = 0, q[$];
	reg [63:0] local_to_system_offset = 0, s1;
	wire sched_valid, sched_value, sched_ready, time_load, sync_enable, xfer_valid_ff;
	wire [63:0] sched_time, time_load_value, out_applied_time_ff, xfer_stamp_ff, xfer_offset_ff;
	wire [63:0] system_time, chassis_time_ff;
	wire [255:0] point_stamp_ff;
	wire [1:0] sched_point;
	wire [3:0] field_out_ff, xfer_data_ff, change_notify = 4'h7;
	wire [31:0] update_interval = 32'h000003e7;
	integer fail_count = 0, n_compared = 0, cyc = 0, i;
	io_timestamp_schedule_unit #(.POINTS(4), .COALESCE_CYCLES(20)) dut (.*);
	owner_ctrl ctrl (.*);
	always #2 clock = ~clock;
	task chk(input string n, input [63:0] e, s);
		n_compared = n_compared + 1;
		if (s !== e) begin
			fail_count = fail_count + 1;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask
	task report_and_stop;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	// Point 3 has no notify, so its change waits for the interval
	task flip(input [1:0] p);
		@(negedge clock);
		field_in[p] = ~field_in[p];
		if (p != 2'd3) q.push_back(field_in);
		repeat (8) @(negedge clock);
	endtask
	// Outputs are looked at mid-cycle, where they have settled
	always @(negedge clock) begin
		cyc <= cyc + 1;
		if (cyc > 3000) begin
			fail_count = fail_count + 1;
			report_and_stop;
		end
		if (xfer_valid_ff === 1'b1 && q.size() > 0) chk("data", q.pop_front(), xfer_data_ff);
	end
	initial begin
		void'($urandom(32'h2bac0c5d));
		local_to_system_offset = {$urandom, $urandom};
		repeat (20) @(negedge clock);
		rst_n = 1;
		for (i = 0; i < 6; i = i + 1) flip(2'($urandom));
		chassis_time_mode = 1;
		flip(2'd0);
		s1 = xfer_stamp_ff;
		flip(2'd1);
		chk("shared", s1, xfer_stamp_ff);
		repeat (30) @(negedge clock);
		flip(2'd2);
		chk("distinct", 1, xfer_stamp_ff !== s1);
		chassis_time_mode = 0;
		ctrl.load(64'h1_0000_0000);
		ctrl.send(64'h2_0000_0010, 2'd2, 1'b1);
		repeat (60) @(negedge clock);
		chk("held", 0, field_out_ff[2]);
		ctrl.load(64'h2_0000_0000);
		repeat (10) @(negedge clock);
		chk("fired", 1, field_out_ff[2]);
		chk("applied", 64'h2_0000_0010, out_applied_time_ff);
		report_and_stop;
	end
endmodule
